// ===== shared_memory_command_queue.sv
`timescale 1ns/1ps
// Overview of operation
// - Internal FIFO takes only the setup command, once, right after reset.
// - Without FIFO load, first request fetches setup command from address 0.
// - Report goes to the status table before the interrupt is raised.
// - One request walks consecutive slots until chain end code stops it.
// - Command table has n 16-byte slots, n power of two up to 128.
// - Slot pointer wraps from slot n-1 back to slot 0.
// - After fetching a transmit command the state byte gets fetched code.
// - Completion writes one of three released codes into the state byte.
// - Fetch raises bus hold request, waits acknowledge, then DMAs the slot.
// - After completion the pointer advances one slot and its state is read.
// - Released code stops the walk; ready code fetches and executes.
// - Each bus hold moves at most one 4 or 8 byte block, then repeats.
// - Report waits for empty status number byte; that byte is written last.
module shared_memory_command_queue (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic cmd_request_pin_in,
  input wire logic soft_cmd_request_bit_in,
  input wire logic irq_clear_pin_in,
  input wire logic soft_irq_clear_bit_in,
  input wire logic fifo_wr_in,
  input wire logic [7:0] fifo_data_in,
  output logic fifo_busy_out,
  output logic setup_done_out,
  output logic [23:0] command_table_base_out,
  output logic [2:0] slot_count_log2_out,
  input wire logic dma_block8_in,
  output logic bus_hold_request_out,
  input wire logic bus_hold_ack_in,
  output logic dma_req_out,
  output logic dma_we_out,
  output logic [23:0] dma_addr_out,
  output logic [7:0] dma_wdata_out,
  input wire logic [7:0] dma_rdata_in,
  input wire logic dma_done_in,
  output logic cmd_start_out,
  output logic [7:0] command_number_byte_out,
  input wire logic cmd_is_transmit_in,
  input wire logic [3:0] cmd_rd_idx_in,
  output logic [7:0] cmd_rd_data_out,
  input wire logic cmd_done_in,
  input wire logic [1:0] cmd_result_in,
  input wire logic rpt_valid_in,
  output logic [3:0] rpt_idx_out,
  input wire logic [7:0] rpt_data_in,
  output logic rpt_ack_out,
  output logic irq_out,
  output logic status_irq_flag_out
);
  import cmdq_pkg::*;

  typedef enum logic [8:0] {
    M_IDLE = 9'b0_0000_0001,
    M_SETUP_FETCH = 9'b0_0000_0010,
    M_CHECK = 9'b0_0000_0100,
    M_FETCH = 9'b0_0000_1000,
    M_MARK = 9'b0_0001_0000,
    M_EXEC = 9'b0_0010_0000,
    M_DONE_WR = 9'b0_0100_0000,
    M_RPT_CHECK = 9'b0_1000_0000,
    M_RPT_WRITE = 9'b1_0000_0000
  } main_e;

  typedef enum logic [3:0] {
    X_IDLE = 4'b0001,
    X_REQ = 4'b0010,
    X_RUN = 4'b0100,
    X_REL = 4'b1000
  } xfer_e;

  // Pin synchronisers: bit 0 request, bit 1 clear, bit 2 hold ack
  logic [2:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < 3; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      lvl_q <= 3'h0;
    end else begin
      s1_q <= {bus_hold_ack_in, irq_clear_pin_in, cmd_request_pin_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  logic req_evt, clr_evt, ack_lvl;
  assign req_evt = (lvl_d[0] & ~lvl_q[0]) | soft_cmd_request_bit_in;
  assign clr_evt = (lvl_d[1] & ~lvl_q[1]) | soft_irq_clear_bit_in;
  assign ack_lvl = lvl_q[2];

  // Main sequencer state
  main_e st_q, st_d;
  logic ret_exec_q, ret_exec_d;
  logic pend_q, pend_d;
  logic setup_q, setup_d;
  logic [4:0] fifo_cnt_q, fifo_cnt_d;
  logic [23:0] base_q, base_d;
  logic [2:0] nlog_q, nlog_d;
  logic [6:0] cslot_q, cslot_d, sslot_q, sslot_d;
  logic [7:0] chk_q, chk_d, cnum_q, cnum_d;
  logic [1:0] res_q, res_d;
  logic done_pend_q, done_pend_d;
  logic irq_q, irq_d;
  logic start_q, start_d, ack_q, ack_d;
  logic xs_q, xs_d, xwe_q, xwe_d, xrot_q, xrot_d;
  logic [23:0] xaddr_q, xaddr_d;
  logic [4:0] xlen_q, xlen_d;
  logic [7:0] xcode_q, xcode_d;

  // Transfer engine state
  xfer_e xst_q, xst_d;
  logic [4:0] cnt_q, cnt_d;
  logic [3:0] bc_q, bc_d;
  logic [23:0] daddr_q, daddr_d;
  logic xf_done;

  // Table geometry
  logic [7:0] n8;
  logic [6:0] slot_mask;
  logic [23:0] cslot_addr, sslot_addr;
  assign n8 = 8'h01 << nlog_q;
  assign slot_mask = 7'(n8 - 8'h01);
  assign cslot_addr = base_q + {13'h0000, cslot_q, 4'h0};
  assign sslot_addr = base_q + {12'h000, n8, 4'h0} + {13'h0000, sslot_q, 4'h0};

  // Read-side capture and queue write
  logic rd_stb, fetching, mem_we, fifo_acc;
  logic [3:0] mem_waddr;
  logic [7:0] mem_wdata;
  assign rd_stb = (xst_q == X_RUN) & dma_done_in & ~xwe_q;
  assign fetching = (st_q == M_FETCH) | (st_q == M_SETUP_FETCH);
  assign fifo_acc = fifo_wr_in & ~setup_q & (st_q == M_IDLE) &
                    (fifo_cnt_q != SLOT_LEN);
  assign mem_we = fifo_acc | (rd_stb & fetching);
  assign mem_waddr = fifo_acc ? fifo_cnt_q[3:0] : cnt_q[3:0];
  assign mem_wdata = fifo_acc ? fifo_data_in : dma_rdata_in;

  cmd_queue_mem u_queue (
    .mclk_in(mclk_in),
    .wr_en_in(mem_we),
    .wr_addr_in(mem_waddr),
    .wr_data_in(mem_wdata),
    .rd_addr_in(cmd_rd_idx_in),
    .rd_data_out(cmd_rd_data_out)
  );

  function automatic logic [7:0] done_code(input logic [1:0] r);
    case (r)
      RES_TX_STOP: done_code = CODE_TX_STOPPED;
      RES_TX_OK: done_code = CODE_TX_NORMAL;
      default: done_code = CODE_DONE_OTHER;
    endcase
  endfunction : done_code

  always_comb begin
    st_d = st_q;
    ret_exec_d = ret_exec_q;
    pend_d = pend_q;
    setup_d = setup_q;
    fifo_cnt_d = fifo_cnt_q;
    base_d = base_q;
    nlog_d = nlog_q;
    cslot_d = cslot_q;
    sslot_d = sslot_q;
    chk_d = chk_q;
    cnum_d = cnum_q;
    res_d = res_q;
    done_pend_d = done_pend_q;
    irq_d = irq_q;
    start_d = 1'b0;
    ack_d = 1'b0;
    xs_d = 1'b0;
    xwe_d = xwe_q;
    xrot_d = xrot_q;
    xaddr_d = xaddr_q;
    xlen_d = xlen_q;
    xcode_d = xcode_q;
    if (fifo_acc) begin
      fifo_cnt_d = fifo_cnt_q + 5'h01;
    end
    if (mem_we & ~setup_q) begin
      case (mem_waddr)
        SETUP_BASE_H: base_d[23:16] = mem_wdata;
        SETUP_BASE_M: base_d[15:8] = mem_wdata;
        SETUP_BASE_L: base_d[7:0] = mem_wdata;
        SETUP_NLOG: nlog_d = mem_wdata[2:0];
        default: ;
      endcase
    end
    if (mem_we & setup_q & (mem_waddr == CMD_NUMBER_IDX)) begin
      cnum_d = mem_wdata;
    end
    if (rd_stb & ~fetching) begin
      chk_d = dma_rdata_in;
    end
    if (cmd_done_in) begin
      done_pend_d = 1'b1;
      res_d = cmd_result_in;
    end
    case (st_q)
      M_IDLE: begin
        if (rpt_valid_in & setup_q) begin
          ret_exec_d = 1'b0;
          st_d = M_RPT_CHECK;
          xs_d = 1'b1;
          xaddr_d = sslot_addr;
          xlen_d = ONE_LEN;
          xwe_d = 1'b0;
          xrot_d = 1'b0;
        end else if (pend_q) begin
          pend_d = 1'b0;
          if (setup_q) begin
            st_d = M_CHECK;
            xs_d = 1'b1;
            xaddr_d = cslot_addr + STATE_BYTE_OFS;
            xlen_d = ONE_LEN;
            xwe_d = 1'b0;
            xrot_d = 1'b0;
          end else if (fifo_cnt_q != 5'h00) begin
            setup_d = 1'b1;
          end else begin
            st_d = M_SETUP_FETCH;
            xs_d = 1'b1;
            xaddr_d = SETUP_ADDR;
            xlen_d = SLOT_LEN;
            xwe_d = 1'b0;
            xrot_d = 1'b0;
          end
        end
      end
      M_SETUP_FETCH: begin
        if (xf_done) begin
          setup_d = 1'b1;
          st_d = M_IDLE;
        end
      end
      M_CHECK: begin
        if (xf_done) begin
          if (chk_q == CODE_READY) begin
            st_d = M_FETCH;
            xs_d = 1'b1;
            xaddr_d = cslot_addr;
            xlen_d = SLOT_LEN;
          end else begin
            st_d = M_IDLE;
          end
        end
      end
      M_FETCH: begin
        if (xf_done) begin
          if (cmd_is_transmit_in) begin
            st_d = M_MARK;
            xs_d = 1'b1;
            xaddr_d = cslot_addr + STATE_BYTE_OFS;
            xlen_d = ONE_LEN;
            xwe_d = 1'b1;
            xcode_d = CODE_FETCHED;
          end else begin
            st_d = M_EXEC;
            start_d = 1'b1;
            done_pend_d = 1'b0;
          end
        end
      end
      M_MARK: begin
        if (xf_done) begin
          st_d = M_EXEC;
          start_d = 1'b1;
          done_pend_d = 1'b0;
        end
      end
      M_EXEC: begin
        if (done_pend_q) begin
          done_pend_d = cmd_done_in;
          st_d = M_DONE_WR;
          xs_d = 1'b1;
          xaddr_d = cslot_addr + STATE_BYTE_OFS;
          xlen_d = ONE_LEN;
          xwe_d = 1'b1;
          xcode_d = done_code(res_q);
        end else if (rpt_valid_in) begin
          ret_exec_d = 1'b1;
          st_d = M_RPT_CHECK;
          xs_d = 1'b1;
          xaddr_d = sslot_addr;
          xlen_d = ONE_LEN;
          xwe_d = 1'b0;
          xrot_d = 1'b0;
        end
      end
      M_DONE_WR: begin
        if (xf_done) begin
          cslot_d = (cslot_q + 7'h01) & slot_mask;
          st_d = M_CHECK;
          xs_d = 1'b1;
          xaddr_d = base_q + {13'h0000, cslot_d, 4'h0} + STATE_BYTE_OFS;
          xlen_d = ONE_LEN;
          xwe_d = 1'b0;
        end
      end
      M_RPT_CHECK: begin
        if (xf_done) begin
          xs_d = 1'b1;
          if (chk_q == CODE_EMPTY) begin
            st_d = M_RPT_WRITE;
            xaddr_d = sslot_addr + NUMBER_BYTE_OFS;
            xlen_d = SLOT_LEN;
            xwe_d = 1'b1;
            xrot_d = 1'b1;
          end
        end
      end
      M_RPT_WRITE: begin
        if (xf_done) begin
          irq_d = 1'b1;
          ack_d = 1'b1;
          xrot_d = 1'b0;
          sslot_d = (sslot_q + 7'h01) & slot_mask;
          st_d = ret_exec_q ? M_EXEC : M_IDLE;
        end
      end
      default: st_d = M_IDLE;
    endcase
    if (clr_evt & ~irq_d) begin
      irq_d = 1'b0;
    end else if (clr_evt & ~(st_q == M_RPT_WRITE && xf_done)) begin
      irq_d = 1'b0;
    end
    if (req_evt) begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      st_q <= M_IDLE;
      ret_exec_q <= 1'b0;
      pend_q <= 1'b0;
      setup_q <= 1'b0;
      fifo_cnt_q <= 5'h00;
      base_q <= BASE_RST;
      nlog_q <= NLOG_RST;
      cslot_q <= 7'h00;
      sslot_q <= 7'h00;
      chk_q <= 8'h00;
      cnum_q <= 8'h00;
      res_q <= 2'h0;
      done_pend_q <= 1'b0;
      irq_q <= 1'b0;
      start_q <= 1'b0;
      ack_q <= 1'b0;
      xs_q <= 1'b0;
      xwe_q <= 1'b0;
      xrot_q <= 1'b0;
      xaddr_q <= 24'h00_0000;
      xlen_q <= 5'h00;
      xcode_q <= 8'h00;
    end else begin
      st_q <= st_d;
      ret_exec_q <= ret_exec_d;
      pend_q <= pend_d;
      setup_q <= setup_d;
      fifo_cnt_q <= fifo_cnt_d;
      base_q <= base_d;
      nlog_q <= nlog_d;
      cslot_q <= cslot_d;
      sslot_q <= sslot_d;
      chk_q <= chk_d;
      cnum_q <= cnum_d;
      res_q <= res_d;
      done_pend_q <= done_pend_d;
      irq_q <= irq_d;
      start_q <= start_d;
      ack_q <= ack_d;
      xs_q <= xs_d;
      xwe_q <= xwe_d;
      xrot_q <= xrot_d;
      xaddr_q <= xaddr_d;
      xlen_q <= xlen_d;
      xcode_q <= xcode_d;
    end
  end

  // Byte offset within the slot; reports rotate so byte 0 goes last
  function automatic logic [3:0] ofs(input logic [4:0] c, input logic rot);
    ofs = rot ? 4'(c[3:0] + 4'h1) : c[3:0];
  endfunction : ofs

  logic [3:0] blk;
  assign blk = dma_block8_in ? BLOCK_LARGE : BLOCK_SMALL;

  always_comb begin
    xst_d = xst_q;
    cnt_d = cnt_q;
    bc_d = bc_q;
    xf_done = 1'b0;
    case (xst_q)
      X_IDLE: begin
        cnt_d = 5'h00;
        bc_d = 4'h0;
        if (xs_q) begin
          xst_d = X_REQ;
        end
      end
      X_REQ: begin
        if (ack_lvl) begin
          xst_d = X_RUN;
        end
      end
      X_RUN: begin
        if (dma_done_in) begin
          cnt_d = cnt_q + 5'h01;
          bc_d = bc_q + 4'h1;
          if (cnt_d == xlen_q || bc_d == blk) begin
            xst_d = X_REL;
          end
        end
      end
      X_REL: begin
        if (!ack_lvl) begin
          bc_d = 4'h0;
          if (cnt_q == xlen_q) begin
            xst_d = X_IDLE;
            xf_done = 1'b1;
          end else begin
            xst_d = X_REQ;
          end
        end
      end
      default: xst_d = X_IDLE;
    endcase
    daddr_d = xaddr_q + {20'h0_0000, ofs(cnt_d, xrot_q)};
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      xst_q <= X_IDLE;
      cnt_q <= 5'h00;
      bc_q <= 4'h0;
      daddr_q <= 24'h00_0000;
    end else begin
      xst_q <= xst_d;
      cnt_q <= cnt_d;
      bc_q <= bc_d;
      daddr_q <= daddr_d;
    end
  end

  assign bus_hold_request_out = (xst_q == X_REQ) | (xst_q == X_RUN);
  assign dma_req_out = (xst_q == X_RUN);
  assign dma_we_out = xwe_q;
  assign dma_addr_out = daddr_q;
  assign rpt_idx_out = ofs(cnt_q, xrot_q);
  assign dma_wdata_out = xrot_q ? rpt_data_in : xcode_q;
  assign fifo_busy_out = setup_q | (fifo_cnt_q == SLOT_LEN);
  assign setup_done_out = setup_q;
  assign command_table_base_out = base_q;
  assign slot_count_log2_out = nlog_q;
  assign cmd_start_out = start_q;
  assign command_number_byte_out = cnum_q;
  assign rpt_ack_out = ack_q;
  assign irq_out = irq_q;
  assign status_irq_flag_out = irq_q;
endmodule : shared_memory_command_queue

// ===== cmdq_pkg.sv
package cmdq_pkg;
  // Slot layout
  localparam int unsigned SLOT_BYTES = 16;
  localparam logic [4:0] SLOT_LEN = 5'h10;
  localparam logic [4:0] ONE_LEN = 5'h01;
  localparam logic [23:0] STATE_BYTE_OFS = 24'h00_0001;
  localparam logic [23:0] NUMBER_BYTE_OFS = 24'h00_0000;
  localparam logic [23:0] SETUP_ADDR = 24'h00_0000;
  // Setup command field positions inside its slot
  localparam logic [3:0] SETUP_BASE_H = 4'h2;
  localparam logic [3:0] SETUP_BASE_M = 4'h3;
  localparam logic [3:0] SETUP_BASE_L = 4'h4;
  localparam logic [3:0] SETUP_NLOG = 4'h5;
  localparam logic [3:0] CMD_NUMBER_IDX = 4'h0;
  // State byte and status number codes
  localparam logic [7:0] CODE_READY = 8'h00;
  localparam logic [7:0] CODE_FETCHED = 8'h0C;
  localparam logic [7:0] CODE_DONE_OTHER = 8'hFC;
  localparam logic [7:0] CODE_TX_STOPPED = 8'hFD;
  localparam logic [7:0] CODE_TX_NORMAL = 8'hFE;
  localparam logic [7:0] CODE_EMPTY = 8'hFF;
  localparam logic [3:0] RELEASED_HI = 4'hF;
  // Completion kinds from the executor
  localparam logic [1:0] RES_OTHER = 2'h0;
  localparam logic [1:0] RES_TX_STOP = 2'h1;
  localparam logic [1:0] RES_TX_OK = 2'h2;
  // Bus hold block sizes
  localparam logic [3:0] BLOCK_SMALL = 4'h4;
  localparam logic [3:0] BLOCK_LARGE = 4'h8;
  // Reset values
  localparam logic [23:0] BASE_RST = 24'h00_0000;
  localparam logic [2:0] NLOG_RST = 3'h0;
endpackage : cmdq_pkg

// ===== cmd_queue_mem.sv
`timescale 1ns/1ps
module cmd_queue_mem (
  input wire logic mclk_in,
  input wire logic wr_en_in,
  input wire logic [3:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [3:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem_q [16];
  logic [7:0] rd_q;

  always_ff @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_q <= mem_q[rd_addr_in];
  end

  assign rd_data_out = rd_q;
endmodule : cmd_queue_mem

// ===== host_mem_model.sv
`timescale 1ns/1ps
module host_mem_model (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic slow_in,
  input wire logic hold_req_in,
  output logic hold_ack_out,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [23:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic done_out
);
  logic [7:0] mem [0:1023];
  logic [2:0] ack_q, ack_d;
  logic [1:0] cnt_q, cnt_d;
  logic [7:0] rd_q, rd_d;
  logic done_q, go;
  // Grant follows the hold request one cycle later, three when slow, both rising and dropping
  assign hold_ack_out = slow_in ? ack_q[2] : ack_q[0];
  assign go = req_in && hold_ack_out && !done_q
    && cnt_q >= (slow_in ? 2'h3 : 2'h1);
  assign rdata_out = rd_q;
  assign done_out = done_q;
  always_comb begin
    ack_d = {ack_q[1:0], hold_req_in};
    cnt_d = cnt_q;
    if (!req_in || done_q) begin
      cnt_d = 2'h0;
    end else if (cnt_q != 2'h3) begin
      cnt_d = cnt_q + 2'h1;
    end
    // A released data bus never repeats the last byte
    rd_d = go ? mem[addr_in[9:0]] : ~rd_q;
  end
  always @(posedge mclk_in) begin
    if (go && we_in) begin
      mem[addr_in[9:0]] <= wdata_in;
    end
    if (!rstn_in) begin
      ack_q <= 3'h0;
      cnt_q <= 2'h0;
      done_q <= 1'b0;
      rd_q <= 8'h00;
    end else begin
      ack_q <= ack_d;
      cnt_q <= cnt_d;
      done_q <= go;
      rd_q <= rd_d;
    end
  end
endmodule : host_mem_model

// ===== cmdq_chk.sv
`timescale 1ns/1ps
module cmdq_chk import cmdq_pkg::*; (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic soft_cmd_request_bit_in,
  input wire logic soft_irq_clear_bit_in,
  input wire logic fifo_busy_out,
  input wire logic setup_done_out,
  input wire logic dma_block8_in,
  input wire logic bus_hold_request_out,
  input wire logic dma_req_out,
  input wire logic dma_we_out,
  input wire logic [23:0] dma_addr_out,
  input wire logic [7:0] dma_wdata_out,
  input wire logic dma_done_in,
  input wire logic cmd_start_out,
  input wire logic cmd_is_transmit_in,
  input wire logic rpt_valid_in,
  input wire logic rpt_ack_out,
  input wire logic irq_out,
  input wire logic status_irq_flag_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  logic [4:0] blk_q, blk_d;
  // Bytes moved within the current hold period
  always_comb begin
    blk_d = blk_q;
    if (!bus_hold_request_out) begin
      blk_d = 5'h00;
    end else if (dma_done_in) begin
      blk_d = blk_q + 5'h01;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      blk_q <= 5'h00;
    end else begin
      blk_q <= blk_d;
    end
  end
  sequence s_soft_req;
    soft_cmd_request_bit_in && setup_done_out && !bus_hold_request_out;
  endsequence
  sequence s_fetched_wr;
    dma_req_out && dma_we_out && dma_wdata_out == CODE_FETCHED
      && !rpt_valid_in;
  endsequence
  property p_req_hold;
    s_soft_req |-> ##[1:8] bus_hold_request_out;
  endproperty
  property p_dma_in_hold;
    $rose(dma_req_out) |-> bus_hold_request_out;
  endproperty
  property p_block;
    blk_q <= (dma_block8_in ? 5'h08 : 5'h04);
  endproperty
  property p_addr;
    dma_req_out && !dma_done_in |=> $stable(dma_addr_out)
      && $stable(dma_we_out);
  endproperty
  property p_irq_rpt;
    $rose(irq_out) |-> ##[0:1] rpt_ack_out;
  endproperty
  property p_irq_flag;
    irq_out == status_irq_flag_out;
  endproperty
  property p_clear;
    soft_irq_clear_bit_in && !rpt_valid_in |=> !irq_out;
  endproperty
  property p_start;
    cmd_start_out |=> !cmd_start_out [*8];
  endproperty
  property p_fetched;
    s_fetched_wr |-> cmd_is_transmit_in;
  endproperty
  property p_setup;
    setup_done_out |=> setup_done_out && fifo_busy_out;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("no hold request after command request");
  a_dma_in_hold: assert property (p_dma_in_hold)
    else $error("byte cycle outside hold period");
  a_block: assert property (p_block)
    else $error("hold period moved too many bytes");
  a_addr: assert property (p_addr)
    else $error("byte cycle changed before done");
  a_irq_rpt: assert property (p_irq_rpt)
    else $error("interrupt without report written");
  a_irq_flag: assert property (p_irq_flag)
    else $error("interrupt pin and flag differ");
  a_clear: assert property (p_clear)
    else $error("soft clear left interrupt set");
  a_start: assert property (p_start)
    else $error("start pulse too long or too close");
  a_fetched: assert property (p_fetched)
    else $error("fetched code on non-transmit command");
  a_setup: assert property (p_setup)
    else $error("setup state or fifo lock lost");
endmodule : cmdq_chk

bind shared_memory_command_queue cmdq_chk i_chk (
  .mclk_in(mclk_in), .rstn_in(rstn_in),
  .soft_cmd_request_bit_in(soft_cmd_request_bit_in),
  .soft_irq_clear_bit_in(soft_irq_clear_bit_in),
  .fifo_busy_out(fifo_busy_out), .setup_done_out(setup_done_out),
  .dma_block8_in(dma_block8_in),
  .bus_hold_request_out(bus_hold_request_out),
  .dma_req_out(dma_req_out), .dma_we_out(dma_we_out),
  .dma_addr_out(dma_addr_out), .dma_wdata_out(dma_wdata_out),
  .dma_done_in(dma_done_in), .cmd_start_out(cmd_start_out),
  .cmd_is_transmit_in(cmd_is_transmit_in), .rpt_valid_in(rpt_valid_in),
  .rpt_ack_out(rpt_ack_out), .irq_out(irq_out),
  .status_irq_flag_out(status_irq_flag_out));

// ===== shared_memory_command_queue_tb.sv
`timescale 1ns/1ps
module shared_memory_command_queue_tb;
  import cmdq_pkg::*;
  logic clk = 0, rstn = 0, rq_pin = 0, rq_bit = 0, cl_pin = 0, cl_bit = 0;
  logic fwr = 0, blk8 = 0, slow = 0, cdone = 0, rvld = 0;
  logic [7:0] fdat = 8'h00, num, rdat, wdat, qdat, pdat;
  logic [3:0] qidx = 4'h0, ridx;
  logic [1:0] res = 2'h0;
  logic [23:0] base, addr, last_wa;
  logic [2:0] nlog;
  logic busy, sdone, hreq, hack, dreq, dwe, done, start, istx, rack;
  logic irq, irqf;
  int error_cnt = 0, checks_done = 0, fetched = 0, starts = 0, acks = 0;
  // Executor treats numbers with the top bit set as transmit commands
  assign istx = num[7];
  assign pdat = 8'h50 + {4'h0, ridx};
  shared_memory_command_queue i_dut (
    .mclk_in(clk), .rstn_in(rstn), .cmd_request_pin_in(rq_pin),
    .soft_cmd_request_bit_in(rq_bit), .irq_clear_pin_in(cl_pin),
    .soft_irq_clear_bit_in(cl_bit), .fifo_wr_in(fwr), .fifo_data_in(fdat),
    .fifo_busy_out(busy), .setup_done_out(sdone),
    .command_table_base_out(base), .slot_count_log2_out(nlog),
    .dma_block8_in(blk8), .bus_hold_request_out(hreq),
    .bus_hold_ack_in(hack), .dma_req_out(dreq), .dma_we_out(dwe),
    .dma_addr_out(addr), .dma_wdata_out(wdat), .dma_rdata_in(rdat),
    .dma_done_in(done), .cmd_start_out(start),
    .command_number_byte_out(num), .cmd_is_transmit_in(istx),
    .cmd_rd_idx_in(qidx), .cmd_rd_data_out(qdat), .cmd_done_in(cdone),
    .cmd_result_in(res), .rpt_valid_in(rvld), .rpt_idx_out(ridx),
    .rpt_data_in(pdat), .rpt_ack_out(rack), .irq_out(irq),
    .status_irq_flag_out(irqf));
  host_mem_model i_host (
    .mclk_in(clk), .rstn_in(rstn), .slow_in(slow), .hold_req_in(hreq),
    .hold_ack_out(hack), .req_in(dreq), .we_in(dwe), .addr_in(addr),
    .wdata_in(wdat), .rdata_out(rdat), .done_out(done));
  always @(posedge clk) begin
    if (done && dwe) begin
      last_wa <= addr;
      if (wdat === CODE_FETCHED) fetched++;
    end
    if (start === 1'b1) starts++;
    if (rack === 1'b1) acks++;
  end
  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_hi(ref logic s);
    int i;
    i = 0;
    while (s !== 1'b1 && i < 3000) begin
      tick(1);
      i++;
    end
    chk("handshake wait", 1, i < 3000);
  endtask : wait_hi
  task automatic pulse(ref logic s, input int n);
    s = 1;
    tick(n);
    s = 0;
  endtask : pulse
  task automatic do_reset;
    rstn = 0;
    tick(5);
    rstn = 1;
    for (int a = 0; a < 1024; a++) i_host.mem[a] = CODE_EMPTY;
  endtask : do_reset
  task automatic put_slot(input int s, input logic [7:0] n,
                          input logic [7:0] st);
    int a;
    a = 'h100 + 16 * s;
    i_host.mem[a] = n;
    for (int k = 2; k < 16; k++) i_host.mem[a + k] = 8'h00;
    i_host.mem[a + 2] = {n[3:0], n[7:4]};
    i_host.mem[a + 1] = st;
  endtask : put_slot
  task automatic exec(input logic [7:0] n, input logic [1:0] r);
    wait_hi(start);
    chk("command number", n, num);
    qidx = 4'h2;
    tick(1);
    chk("queue byte", {n[3:0], n[7:4]}, qdat);
    res = r;
    cdone = 1;
    tick(1);
    cdone = 0;
  endtask : exec
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial forever #12.5 clk = ~clk;
  initial begin
    #(40000 * 25);
    error_cnt++;
    conclude();
  end
  initial begin
    do_reset();
    chk("fifo busy", 0, busy);
    chk("irq", 0, irq);
    // Setup image: base 000100, log2 of slot count 2
    i_host.mem[2] = 8'h00;
    i_host.mem[3] = 8'h01;
    i_host.mem[4] = 8'h00;
    i_host.mem[5] = 8'h02;
    pulse(rq_bit, 1);
    wait_hi(sdone);
    chk("table base", 24'h00_0100, base);
    chk("slot count", 3'h2, nlog);
    $display("memory setup test ended");
    do_reset();
    for (int k = 0; k < 16; k++) begin
      fwr = 1;
      fdat = (k == 3) ? 8'h01 : (k == 5) ? 8'h02 : 8'h00;
      tick(1);
    end
    fwr = 0;
    pulse(rq_bit, 1);
    wait_hi(sdone);
    chk("table base", 24'h00_0100, base);
    chk("slot count", 3'h2, nlog);
    chk("fifo busy", 1, busy);
    $display("fifo setup test ended");
    put_slot(0, 8'h11, CODE_READY);
    put_slot(1, 8'h82, CODE_READY);
    put_slot(2, 8'h13, CODE_READY);
    pulse(rq_bit, 1);
    exec(8'h11, RES_OTHER);
    exec(8'h82, RES_TX_STOP);
    exec(8'h13, RES_TX_OK);
    tick(300);
    chk("starts", 3, starts);
    chk("state 0", CODE_DONE_OTHER, i_host.mem['h101]);
    chk("state 1", CODE_TX_STOPPED, i_host.mem['h111]);
    chk("state 2", CODE_TX_NORMAL, i_host.mem['h121]);
    chk("fetched writes", 1, fetched);
    chk("slot 2 released", RELEASED_HI, i_host.mem['h121][7:4]);
    $display("chain test ended");
    blk8 = 1;
    slow = 1;
    put_slot(3, 8'h84, CODE_READY);
    chk("slot 0 free", RELEASED_HI, i_host.mem['h101][7:4]);
    put_slot(0, 8'h15, CODE_READY);
    pulse(rq_pin, 4);
    exec(8'h84, 2'h3);
    exec(8'h15, RES_OTHER);
    tick(300);
    chk("starts", 5, starts);
    chk("state 3", CODE_DONE_OTHER, i_host.mem['h131]);
    chk("fetched writes", 2, fetched);
    $display("wrap test ended");
    rvld = 1;
    wait_hi(rack);
    rvld = 0;
    chk("irq", 1, irq);
    for (int k = 0; k < 16; k++) begin
      chk("report byte", 8'h50 + k, i_host.mem['h140 + k]);
    end
    chk("last report write", 24'h00_0140, last_wa);
    pulse(cl_bit, 1);
    chk("irq", 0, irq);
    i_host.mem['h150] = 8'h33;
    rvld = 1;
    tick(100);
    chk("report acks", 1, acks);
    i_host.mem['h150] = CODE_EMPTY;
    wait_hi(rack);
    rvld = 0;
    chk("report byte", 8'h50, i_host.mem['h150]);
    chk("irq", 1, irq);
    chk("irq flag", 1, irqf);
    pulse(cl_pin, 4);
    tick(5);
    chk("irq", 0, irq);
    chk("irq flag", 0, irqf);
    chk("no new report", CODE_EMPTY, i_host.mem['h160]);
    $display("report test ended");
    conclude();
  end
endmodule : shared_memory_command_queue_tb
